// [scfg_regs.sv]
`timescale 1ns/1ns
module scfg_regs
    import scfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // external setup load
    input  wire logic        setup_load,
    input  wire logic [31:0] setup_value,
    // bridge mode
    input  wire scfg_mode_t  bridge_mode,
    // window lookup
    input  wire logic [31:0] look_addr,
    output scfg_hit_t        look_hit,
    output logic      [31:0] look_xaddr,
    // configuration outputs
    output logic      [8:0]  arb_prio,
    output logic      [3:0]  cache_line,
    output logic      [7:0]  sec_latency
);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    scfg_req_t req;
    logic      wr_prio;
    logic      wr_cls;
    logic      wr_base;
    logic      wr_setup;
    logic      wr_xlat;
    logic      lat_writable;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign req      = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign wr_prio  = req.wr && hit(req.addr, SCFG_OFF_ARB_PRIO);
    assign wr_cls   = req.wr && hit(req.addr, SCFG_OFF_CLS_LAT);
    assign wr_base  = req.wr && hit(req.addr, SCFG_OFF_MEM0_BASE);
    assign wr_setup = req.wr && hit(req.addr, SCFG_OFF_MEM0_SETUP);
    assign wr_xlat  = req.wr && hit(req.addr, SCFG_OFF_MEM0_XLAT);
    // forward pci opens it for writes
    assign lat_writable = (bridge_mode == SCFG_MODE_FORWARD_PCI);

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic                       prio_own_q;
    logic                       prio_own_d;
    logic [SCFG_PRIO_EXT_N-1:0] prio_ext_q;
    logic [SCFG_PRIO_EXT_N-1:0] prio_ext_d;
    logic [SCFG_CLS_N-1:0]      cls_q;
    logic [SCFG_CLS_N-1:0]      cls_d;
    logic [7:0]                 lat_q;
    logic [7:0]                 lat_d;
    logic [31:0]                setup_q;
    logic [31:0]                setup_d;
    logic [31:0]                xlat_q;
    logic [31:0]                xlat_d;
    logic [SCFG_BASE_N-1:0]     base;
    logic [31:0]                rdata_q;
    logic [31:0]                rdata_d;

    assign prio_own_d = wr_prio ? req.wdata[SCFG_PRIO_OWN_BIT] : prio_own_q;
    assign prio_ext_d = wr_prio ? req.wdata[SCFG_PRIO_EXT_LSB +: SCFG_PRIO_EXT_N] : prio_ext_q;
    assign cls_d = wr_cls ? req.wdata[SCFG_CLS_LSB +: SCFG_CLS_N] : cls_q;
    assign lat_d = (wr_cls && lat_writable) ? req.wdata[SCFG_LAT_LSB +: 8] : lat_q;
    // setup from software or external loader, loader wins
    assign setup_d = setup_load ? setup_value : (wr_setup ? req.wdata : setup_q);
    assign xlat_d  = wr_xlat ? req.wdata : xlat_q;

    // one short block per register keeps each reset value beside its flop
    always_ff @(posedge clk) begin
        if (rst) begin
            prio_own_q <= SCFG_PRIO_OWN_RST;
        end else begin
            prio_own_q <= prio_own_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prio_ext_q <= SCFG_PRIO_EXT_RST;
        end else begin
            prio_ext_q <= prio_ext_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cls_q <= SCFG_CLS_RST;
        end else begin
            cls_q <= cls_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lat_q <= SCFG_LAT_RST;
        end else begin
            lat_q <= lat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            setup_q <= SCFG_SETUP_RST;
        end else begin
            setup_q <= setup_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xlat_q <= SCFG_XLAT_RST;
        end else begin
            xlat_q <= xlat_d;
        end
    end

    // base bits writable per setup bit
    scfg_wmask_reg #(
        .W   (SCFG_BASE_N),
        .RST (SCFG_BASE_RST)
    ) u_base (
        .clk   (clk),
        .rst   (rst),
        .we    (wr_base),
        .wmask (setup_q[31:SCFG_BASE_LSB]),
        .wdata (req.wdata[31:SCFG_BASE_LSB]),
        .q     (base)
    );

    // ---------------------------------------------------------------
    // window decode
    // ---------------------------------------------------------------
    scfg_dec_t dec;

    // csr hit below 4KB, forward above
    scfg_win_decode u_dec (
        .clk       (clk),
        .rst       (rst),
        .base      (base),
        .size_mask (setup_q[31:SCFG_BASE_LSB]),
        .enable    (setup_q[31]),
        .xlat_base (xlat_q),
        .addr      (look_addr),
        .dec       (dec)
    );

    assign look_hit   = dec.hit;
    assign look_xaddr = dec.addr;

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    logic [31:0] rd_prio;
    logic [31:0] rd_cls;
    logic [31:0] rd_base;

    assign rd_prio = {1'b0, prio_ext_q, prio_own_q, 22'h000000};
    assign rd_cls  = {8'h00, 1'b0, SCFG_HDR_CFG_RST, lat_q, 2'b00, cls_q, 2'b00};
    assign rd_base = {base, SCFG_BASE_LOW_RO};

    always_comb begin
        rdata_d = 32'h00000000;
        if (req.rd) begin
            case (req.addr)
                SCFG_OFF_ARB_PRIO:   rdata_d = rd_prio;
                SCFG_OFF_CLS_LAT:    rdata_d = rd_cls;
                SCFG_OFF_MEM0_BASE:  rdata_d = rd_base;
                SCFG_OFF_MEM0_SETUP: rdata_d = setup_q;
                SCFG_OFF_MEM0_XLAT:  rdata_d = xlat_q;
                SCFG_OFF_MODE:       rdata_d = {30'h00000000, bridge_mode};
                default:             rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata   = rdata_q;
    assign arb_prio    = {prio_ext_q, prio_own_q};
    assign cache_line  = cls_q;
    assign sec_latency = lat_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_own_prio_reset: assert property (@(posedge clk)
        $past(rst) |-> arb_prio[0] == 1'b1)
        else $error("own priority not 1 after reset");
    a_ext_prio_write: assert property (@(posedge clk) disable iff (rst)
        wr_prio |=> arb_prio[8:1] == $past(reg_wdata[30:23]))
        else $error("external priorities not written");
    a_cls_low_zero: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_CLS_LAT |-> reg_rdata[1:0] == 2'b00)
        else $error("cache line bits 1:0 not zero");
    a_cls_write: assert property (@(posedge clk) disable iff (rst)
        wr_cls |=> cache_line == $past(reg_wdata[5:2]))
        else $error("cache line select not written");
    a_cls_high_zero: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_CLS_LAT |-> reg_rdata[7:6] == 2'b00)
        else $error("cache line bits 7:6 not zero");
    a_lat_readback: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == SCFG_OFF_CLS_LAT |=> reg_rdata[15:8] == $past(lat_q))
        else $error("latency field misplaced");
    a_lat_rev_ro: assert property (@(posedge clk) disable iff (rst)
        wr_cls && bridge_mode == SCFG_MODE_REVERSE |=> $stable(sec_latency))
        else $error("latency written in reverse mode");
    a_lat_fwd_rw: assert property (@(posedge clk) disable iff (rst)
        wr_cls && bridge_mode == SCFG_MODE_FORWARD_PCI
        |=> sec_latency == $past(reg_wdata[15:8]))
        else $error("latency not written in forward mode");
    a_hdr_zero: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_CLS_LAT |-> reg_rdata[31:16] == 16'h0000)
        else $error("header type not zero");
    a_base_low_ro: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_MEM0_BASE |-> reg_rdata[11:0] == 12'h000)
        else $error("base low bits not zero");
    a_base_masked: assert property (@(posedge clk) disable iff (rst)
        wr_base |=> ((base ^ $past(base)) & ~$past(setup_q[31:12])) == 20'h00000)
        else $error("base bit written without setup bit");

    // ---------------------------------------------------------------
    // reset, hold and write checks
    // ---------------------------------------------------------------
    a_ext_prio_reset: assert property (@(posedge clk)
        $past(rst) |-> arb_prio[8:1] == SCFG_PRIO_EXT_RST)
        else $error("external priorities not 0 after reset");
    a_cls_reset: assert property (@(posedge clk)
        $past(rst) |-> cache_line == SCFG_CLS_RST)
        else $error("cache line select not 0 after reset");
    a_lat_reset: assert property (@(posedge clk)
        $past(rst) |-> sec_latency == SCFG_LAT_RST)
        else $error("latency timer not 0 after reset");
    a_base_reset: assert property (@(posedge clk)
        $past(rst) |-> base == SCFG_BASE_RST)
        else $error("base not 0 after reset");
    a_setup_reset: assert property (@(posedge clk)
        $past(rst) |-> setup_q == SCFG_SETUP_RST)
        else $error("setup not 0 after reset");
    // rst in the antecedent keeps the release edge from judging pre-reset state
    a_prio_hold: assert property (@(posedge clk) disable iff (rst)
        !rst && !wr_prio |=> $stable(arb_prio))
        else $error("priorities changed without a write");
    a_cls_hold: assert property (@(posedge clk) disable iff (rst)
        !rst && !wr_cls |=> $stable(cache_line))
        else $error("cache line changed without a write");
    a_lat_hold: assert property (@(posedge clk) disable iff (rst)
        !rst && !wr_cls |=> $stable(sec_latency))
        else $error("latency changed without a write");
    a_own_prio_write: assert property (@(posedge clk) disable iff (rst)
        wr_prio |=> arb_prio[0] == $past(reg_wdata[22]))
        else $error("own priority not written");
    a_lat_pcix_ro: assert property (@(posedge clk) disable iff (rst)
        wr_cls && bridge_mode == SCFG_MODE_FORWARD_PCIX |=> $stable(sec_latency))
        else $error("latency written outside forward pci mode");
    a_setup_load: assert property (@(posedge clk) disable iff (rst)
        setup_load |=> setup_q == $past(setup_value))
        else $error("external setup load lost");
    a_setup_write: assert property (@(posedge clk) disable iff (rst)
        wr_setup && !setup_load |=> setup_q == $past(reg_wdata))
        else $error("setup not written");
    a_base_write: assert property (@(posedge clk) disable iff (rst)
        wr_base |=> (base & $past(setup_q[31:12]))
                    == ($past(reg_wdata[31:12]) & $past(setup_q[31:12])))
        else $error("writable base bit not written");

    // ---------------------------------------------------------------
    // read data checks
    // ---------------------------------------------------------------
    a_prio_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_ARB_PRIO
        |-> {reg_rdata[31], reg_rdata[21:0]} == 23'h000000)
        else $error("priority reserved bits not zero");
    a_prio_readback: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == SCFG_OFF_ARB_PRIO |=> reg_rdata[30:22] == $past(arb_prio))
        else $error("priority readback wrong");
    a_cls_readback: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == SCFG_OFF_CLS_LAT |=> reg_rdata[5:2] == $past(cache_line))
        else $error("cache line readback wrong");
    a_hdr_single_fn: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_CLS_LAT |-> reg_rdata[23] == 1'b0)
        else $error("single function bit not zero");
    a_base_space: assert property (@(posedge clk) disable iff (rst)
        $past(reg_rd) && $past(reg_addr) == SCFG_OFF_MEM0_BASE |-> reg_rdata[2:0] == 3'b000)
        else $error("base space or type bits not zero");
    a_base_readback: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == SCFG_OFF_MEM0_BASE |=> reg_rdata[31:12] == $past(base))
        else $error("base readback wrong");

    // ---------------------------------------------------------------
    // window checks
    // ---------------------------------------------------------------
    a_win_disabled: assert property (@(posedge clk) disable iff (rst)
        !setup_q[31] |=> look_hit == SCFG_HIT_NONE)
        else $error("hit while window disabled");
    a_csr_low: assert property (@(posedge clk) disable iff (rst)
        look_hit == SCFG_HIT_CSR |-> look_xaddr[31:12] == 20'h00000)
        else $error("csr offset beyond 4KB");
    a_fwd_above: assert property (@(posedge clk) disable iff (rst)
        look_hit == SCFG_HIT_FWD
        |-> ($past(look_addr) & ~{$past(setup_q[31:12]), 12'h000}) >= SCFG_CSR_WINDOW)
        else $error("forward hit inside csr window");
    a_fwd_offset: assert property (@(posedge clk) disable iff (rst)
        look_hit == SCFG_HIT_FWD |-> look_xaddr[11:0] == $past(look_addr[11:0]))
        else $error("forwarded offset lost");
    a_fwd_xlat: assert property (@(posedge clk) disable iff (rst)
        look_hit == SCFG_HIT_FWD
        |-> (look_xaddr & {$past(setup_q[31:12]), 12'h000})
            == ($past(xlat_q) & {$past(setup_q[31:12]), 12'h000}))
        else $error("forwarded address not translated");

endmodule

// [scfg_pkg.sv]
package scfg_pkg;

    // ---------------------------------------------------------------
    // register offsets (byte addresses, config space)
    // ---------------------------------------------------------------
    localparam logic [7:0] SCFG_OFF_ARB_PRIO  = 8'h48;
    localparam logic [7:0] SCFG_OFF_CLS_LAT   = 8'h4C;
    localparam logic [7:0] SCFG_OFF_MEM0_BASE = 8'h50;
    localparam logic [7:0] SCFG_OFF_MEM0_SETUP = 8'hE4;
    localparam logic [7:0] SCFG_OFF_MEM0_XLAT = 8'hE0;
    localparam logic [7:0] SCFG_OFF_MODE      = 8'hF0;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SCFG_PRIO_OWN_BIT = 22;
    localparam int SCFG_PRIO_EXT_LSB = 23;
    localparam int SCFG_PRIO_EXT_N   = 8;
    localparam int SCFG_CLS_LSB      = 2;
    localparam int SCFG_CLS_N        = 4;
    localparam int SCFG_LAT_LSB      = 8;
    localparam int SCFG_HDR_LSB      = 16;
    localparam int SCFG_BASE_LSB     = 12;
    localparam int SCFG_BASE_N       = 20;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic                      SCFG_PRIO_OWN_RST = 1'h1;
    localparam logic [SCFG_PRIO_EXT_N-1:0] SCFG_PRIO_EXT_RST = 8'h00;
    localparam logic [SCFG_CLS_N-1:0]     SCFG_CLS_RST      = 4'h0;
    localparam logic [7:0]                SCFG_LAT_RST      = 8'h00;
    localparam logic [6:0]                SCFG_HDR_CFG_RST  = 7'h00;
    localparam logic [SCFG_BASE_N-1:0]    SCFG_BASE_RST     = 20'h00000;
    localparam logic [31:0]               SCFG_SETUP_RST    = 32'h00000000;
    localparam logic [31:0]               SCFG_XLAT_RST     = 32'h00000000;
    localparam logic [11:0]               SCFG_BASE_LOW_RO  = 12'h000;
    localparam logic [31:0]               SCFG_CSR_WINDOW   = 32'h00001000;

    // ---------------------------------------------------------------
    // bridge modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SCFG_MODE_REVERSE     = 2'b00,
        SCFG_MODE_FORWARD_PCI = 2'b01,
        SCFG_MODE_FORWARD_PCIX = 2'b10
    } scfg_mode_t;

    typedef enum logic [1:0] {
        SCFG_HIT_NONE = 2'b00,
        SCFG_HIT_CSR  = 2'b01,
        SCFG_HIT_FWD  = 2'b10
    } scfg_hit_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scfg_req_t;

    typedef struct packed {
        scfg_hit_t   hit;
        logic [31:0] addr;
    } scfg_dec_t;

endpackage

// [scfg_wmask_reg.sv]
`timescale 1ns/1ns
module scfg_wmask_reg
    import scfg_pkg::*;
#(
    parameter int                W   = 20,
    parameter logic [W-1:0]      RST = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // write side
    input  wire logic         we,
    input  wire logic [W-1:0] wmask,
    input  wire logic [W-1:0] wdata,
    // state
    output logic      [W-1:0] q
);

    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    assign q = q_q;

    // per-bit writable only where the mask allows
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign q_d[i] = (we && wmask[i]) ? wdata[i] : q_q[i];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            q_q <= RST;
        end else begin
            q_q <= q_d;
        end
    end

endmodule

// [scfg_win_decode.sv]
`timescale 1ns/1ns
module scfg_win_decode
    import scfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // window setup
    input  wire logic [19:0] base,
    input  wire logic [19:0] size_mask,
    input  wire logic        enable,
    input  wire logic [31:0] xlat_base,
    // lookup
    input  wire logic [31:0] addr,
    output scfg_dec_t        dec
);

    scfg_dec_t dec_q;
    scfg_dec_t dec_d;
    logic      in_win;
    logic      in_csr;
    logic [31:0] win_mask;
    logic [31:0] offs;

    assign win_mask = {size_mask, 12'h000};
    assign in_win   = enable && ((addr & win_mask) == ({base, 12'h000} & win_mask));
    assign offs     = addr & ~win_mask;
    assign in_csr   = offs < SCFG_CSR_WINDOW;
    assign dec      = dec_q;

    always_comb begin
        dec_d = '{hit: SCFG_HIT_NONE, addr: 32'h00000000};
        if (in_win && in_csr) begin
            dec_d.hit  = SCFG_HIT_CSR;
            dec_d.addr = offs;
        end else if (in_win) begin
            dec_d.hit  = SCFG_HIT_FWD;
            dec_d.addr = (xlat_base & win_mask) | offs;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dec_q <= '{hit: SCFG_HIT_NONE, addr: 32'h00000000};
        end else begin
            dec_q <= dec_d;
        end
    end

endmodule

// [tb_secondary_config_header_regs.sv]
`timescale 1ns/1ns
module tb_secondary_config_header_regs
    import scfg_pkg::*;
;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        setup_load;
    logic [31:0] setup_value;
    scfg_mode_t  bridge_mode;
    logic [31:0] look_addr;
    scfg_hit_t   look_hit;
    logic [31:0] look_xaddr;
    logic [8:0]  arb_prio;
    logic [3:0]  cache_line;
    logic [7:0]  sec_latency;
    int          fails;
    int          comparisons;

    scfg_regs u_dut (
        .clk         (clk),
        .rst         (rst),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .setup_load  (setup_load),
        .setup_value (setup_value),
        .bridge_mode (bridge_mode),
        .look_addr   (look_addr),
        .look_hit    (look_hit),
        .look_xaddr  (look_xaddr),
        .arb_prio    (arb_prio),
        .cache_line  (cache_line),
        .sec_latency (sec_latency)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand one cycle only, then must fall back to zero
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp, "read");
        @(posedge clk);
        #1 chk(reg_rdata, 32'h0, "idle");
    endtask

    task automatic look(input logic [31:0] a, input scfg_hit_t h, input logic [31:0] xa);
        @(posedge clk);
        look_addr <= a;
        @(posedge clk);
        #1 chk({30'h0, look_hit}, {30'h0, h}, "hit");
        if (h != SCFG_HIT_NONE) chk(look_xaddr, xa, "xaddr");
    endtask

    task automatic mode(input scfg_mode_t m);
        @(posedge clk);
        bridge_mode <= m;
    endtask

    // exactly two reset edges; callers return just off a clock edge
    task automatic pulse_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(SCFG_OFF_ARB_PRIO, 32'h00400000);
        rd(SCFG_OFF_CLS_LAT, 32'h0);
        rd(SCFG_OFF_MEM0_BASE, 32'h0);
        rd(SCFG_OFF_MEM0_SETUP, 32'h0);
        rd(SCFG_OFF_MEM0_XLAT, 32'h0);
        look(32'h12340010, SCFG_HIT_NONE, 32'h0);
        chk({23'h0, arb_prio}, 32'h00000001, "prio out");
        chk({20'h0, cache_line, sec_latency}, 32'h0, "cls lat out");
        $display("test reset done");
    endtask

    task automatic close_out();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        setup_load = 1'b0;
        setup_value = 32'h0;
        bridge_mode = SCFG_MODE_REVERSE;
        look_addr = 32'h0;
        fails = 0;
        comparisons = 0;
        pulse_reset();
        wr(SCFG_OFF_ARB_PRIO, 32'hFFFFFFFF);
        rd(SCFG_OFF_ARB_PRIO, 32'h7FC00000);
        for (int i = 0; i < 9; i++) begin
            wr(SCFG_OFF_ARB_PRIO, 32'h1 << (22 + i));
            #1 chk({23'h0, arb_prio}, 32'h1 << i, "prio bit");
            rd(SCFG_OFF_ARB_PRIO, 32'h1 << (22 + i));
        end
        $display("test priority done");
        wr(SCFG_OFF_CLS_LAT, 32'hFFFFFFFF);
        rd(SCFG_OFF_CLS_LAT, 32'h0000003C);
        for (int i = 0; i < 4; i++) begin
            wr(SCFG_OFF_CLS_LAT, 32'h1 << (2 + i));
            #1 chk({28'h0, cache_line}, 32'h1 << i, "cls bit");
        end
        mode(SCFG_MODE_FORWARD_PCI);
        wr(SCFG_OFF_CLS_LAT, 32'hFFFFA5FF);
        rd(SCFG_OFF_CLS_LAT, 32'h0000A53C);
        chk({24'h0, sec_latency}, 32'h000000A5, "lat out");
        mode(SCFG_MODE_FORWARD_PCIX);
        rd(SCFG_OFF_MODE, 32'h00000002);
        wr(SCFG_OFF_CLS_LAT, 32'h00005A00);
        rd(SCFG_OFF_CLS_LAT, 32'h0000A500);
        mode(SCFG_MODE_REVERSE);
        wr(SCFG_OFF_CLS_LAT, 32'h0000003C);
        rd(SCFG_OFF_CLS_LAT, 32'h0000A53C);
        $display("test cache line and timer done");
        wr(SCFG_OFF_MEM0_BASE, 32'hFFFFFFFF);
        rd(SCFG_OFF_MEM0_BASE, 32'h0);
        wr(SCFG_OFF_MEM0_SETUP, 32'hFFFFF000);
        wr(SCFG_OFF_MEM0_BASE, 32'hFFFFFFFF);
        rd(SCFG_OFF_MEM0_BASE, 32'hFFFFF000);
        wr(SCFG_OFF_MEM0_BASE, 32'h0);
        // external loader and software write collide; loader must win
        @(posedge clk);
        setup_load  <= 1'b1;
        setup_value <= 32'h80000000;
        reg_wr      <= 1'b1;
        reg_addr    <= SCFG_OFF_MEM0_SETUP;
        reg_wdata   <= 32'h00001000;
        @(posedge clk);
        setup_load  <= 1'b0;
        reg_wr      <= 1'b0;
        rd(SCFG_OFF_MEM0_SETUP, 32'h80000000);
        wr(SCFG_OFF_MEM0_BASE, 32'hFFFFFFFF);
        rd(SCFG_OFF_MEM0_BASE, 32'h80000000);
        $display("test base register done");
        wr(SCFG_OFF_MEM0_SETUP, 32'hFFFF0000);
        wr(SCFG_OFF_MEM0_BASE, 32'h12340000);
        wr(SCFG_OFF_MEM0_XLAT, 32'hABCD0000);
        rd(SCFG_OFF_MEM0_XLAT, 32'hABCD0000);
        look(32'h12340010, SCFG_HIT_CSR, 32'h00000010);
        look(32'h12340FFF, SCFG_HIT_CSR, 32'h00000FFF);
        look(32'h12341000, SCFG_HIT_FWD, 32'hABCD1000);
        look(32'h12345678, SCFG_HIT_FWD, 32'hABCD5678);
        look(32'h12350000, SCFG_HIT_NONE, 32'h0);
        wr(SCFG_OFF_MEM0_SETUP, 32'h7FFF0000);
        look(32'h12340010, SCFG_HIT_NONE, 32'h0);
        $display("test window lookup done");
        rd(8'h00, 32'h0);
        rd(8'h44, 32'h0);
        $display("test unmapped done");
        pulse_reset();
        close_out();
    end

    // run needs under two hundred cycles; the 20000-cycle limit is a hang
    initial begin
        #200000;
        fails++;
        close_out();
    end
endmodule
